// ===== irq_pkg.sv
// Constants, register map and carrier types of the interrupt request controller
package irq_pkg;

  // ----------------------------------------------------------------
  // Register map (word index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int REG_EDGE_SEL = 0;
  localparam int REG_CTRL_A = 1;
  localparam int REG_CTRL_B = 2;
  localparam int REG_CTRL_C = 3;
  localparam int REG_GRP_A = 4;
  localparam int REG_GRP_B = 5;
  localparam int REG_GRP_C = 6;
  localparam int REG_EVT_STATUS = 7;
  localparam int REG_EVT_MASK = 8;
  localparam int REG_COUNT = 9;
  localparam int WORD_LSB = 2;
  localparam int BUS_DW = 32;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int EMI_BIT = 0;
  localparam int EDGE_SEL_W = 2;
  localparam int NUM_PINS = 2;
  localparam logic [EDGE_SEL_W-1:0] EDGE_OFF = 2'h0;
  localparam logic [EDGE_SEL_W-1:0] EDGE_RISE = 2'h1;
  localparam logic [EDGE_SEL_W-1:0] EDGE_FALL = 2'h2;
  localparam logic [EDGE_SEL_W-1:0] EDGE_BOTH = 2'h3;

  // Primary sources; index order is also the vectoring priority, 0 first
  localparam int NUM_PRI = 11;
  localparam int P_PIN0 = 0;
  localparam int P_PIN1 = 1;
  localparam int P_CMP = 2;
  localparam int P_MF0 = 3;
  localparam int P_ADC = 6;
  localparam int P_TB0 = 7;
  localparam int P_TB1 = 8;
  localparam int P_IIC = 9;
  localparam int P_UART = 10;
  localparam int PRI_REG [NUM_PRI] = '{REG_CTRL_A, REG_CTRL_C, REG_CTRL_A, REG_CTRL_A, REG_CTRL_B,
    REG_CTRL_B, REG_CTRL_B, REG_CTRL_B, REG_CTRL_C, REG_CTRL_C, REG_CTRL_C};
  localparam int PRI_FLAG_BIT [NUM_PRI] = '{4, 5, 5, 6, 4, 5, 6, 7, 4, 6, 7};
  localparam int PRI_EN_BIT [NUM_PRI] = '{1, 1, 2, 3, 0, 1, 2, 3, 0, 2, 3};

  // Multi-function sub-sources; group g feeds summary P_MF0 + g
  localparam int NUM_SUB = 8;
  localparam int NUM_GRP = 3;
  localparam int S_T0P = 0;
  localparam int S_T0A = 1;
  localparam int S_T1P = 2;
  localparam int S_T1A = 3;
  localparam int S_T2P = 4;
  localparam int S_T2A = 5;
  localparam int S_LVD = 6;
  localparam int S_EEP = 7;
  localparam int SUB_GRP [NUM_SUB] = '{0, 0, 1, 1, 1, 1, 2, 2};
  localparam int SUB_FLAG_BIT [NUM_SUB] = '{4, 5, 4, 5, 6, 7, 4, 5};
  localparam int SUB_EN_BIT [NUM_SUB] = '{0, 1, 0, 1, 2, 3, 0, 1};

  // Block event status bits
  localparam int NUM_EVT = 3;
  localparam int E_SERVICE = 0;
  localparam int E_WAKE = 1;
  localparam int E_STACK_BLOCK = 2;
  localparam int VEC_W = 4;

  typedef logic [NUM_PRI-1:0] pri_vec_type;
  typedef logic [NUM_SUB-1:0] sub_vec_type;

  // One-cycle request pulses from the on-chip peripherals
  typedef struct packed {
    logic comparator;
    logic converter;
    logic timebase0;
    logic timebase1;
    logic two_wire;
    logic async_serial;
    logic timer0_cmp_p;
    logic timer0_cmp_a;
    logic timer1_cmp_p;
    logic timer1_cmp_a;
    logic timer2_cmp_p;
    logic timer2_cmp_a;
    logic voltage_detect;
    logic eeprom;
  } periph_event_type;

  typedef enum {BUS_IDLE, BUS_WR, BUS_RD_WAIT, BUS_RD_DONE} bus_state_type;

endpackage

// ===== irq_pin_edge.sv
// Synchroniser and selectable edge detector for one external interrupt pin
`timescale 1ns/1ns
module irq_pin_edge #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin,
  input wire logic [irq_pkg::EDGE_SEL_W-1:0] edge_sel,
  output logic hit_q
);
  import irq_pkg::*;

  logic [SYNC_STAGES-1:0] sync_q;
  logic prev_q;
  logic pin_s;
  logic rise;
  logic fall;

  initial begin
    if (SYNC_STAGES < 2) begin
      $error("irq_pin_edge needs at least two synchroniser stages");
    end
  end

  // ----------------------------------------------------------------
  // Synchroniser; only the last stage and its delayed copy are compared
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_q <= '0;
      prev_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[SYNC_STAGES-2:0], pin};
      prev_q <= pin_s;
    end
  end

  assign pin_s = sync_q[SYNC_STAGES-1];
  assign rise = pin_s & ~prev_q;
  assign fall = ~pin_s & prev_q;

  // Edge qualification, one pulse per transition
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hit_q <= 1'b0;
    end else begin
      case (edge_sel)
        EDGE_OFF: hit_q <= 1'b0;
        EDGE_RISE: hit_q <= rise;
        EDGE_FALL: hit_q <= fall;
        EDGE_BOTH: hit_q <= rise | fall;
        default: hit_q <= 1'b0;
      endcase
    end
  end

  a_rise_detect: assert property (@(posedge clk) disable iff (!arst_n)
    (edge_sel == EDGE_RISE && rise) |=> hit_q)
    else $error("rising edge missed");
  a_fall_only: assert property (@(posedge clk) disable iff (!arst_n)
    (edge_sel == EDGE_FALL && !fall) |=> !hit_q)
    else $error("pulse without falling edge");
  a_single_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    (hit_q && edge_sel != EDGE_BOTH) |=> !hit_q)
    else $error("one transition gave two pulses");

endmodule

// ===== mcu_irq_ctrl.sv
// Interrupt request flags, enables, vectoring request and AHB-Lite register slave
//
// Summary of operation
// - Pin 0 edge select in bits 1:0: off, rising, falling, both.
// - Pin 1 edge select in bits 3:2, same encoding.
// - Global enable bit blocks every request from the core when clear.
// - Flags read one while pending; enables pass their source when one.
// - Three primary registers hold the directly vectored sources and summaries.
// - First primary register: group0, comparator, pin0 flags 6:4, enables 3:1.
// - Second: time base 0, converter, group2, group1 flags 7:4, enables 3:0.
// - Third: async serial, two-wire, pin 1, time base 1 flags, enables.
// - Group registers hold timer, EEPROM and voltage-detect sub-flags and enables.
// - Unimplemented bits read as zero.
// - Requests come from both pins and all internal peripheral sources.
// - An accepted request is held to the core until it acknowledges service or the return stack fills.
// - A flag vectors only while its own enable is set.
// - Service entry clears the global enable; later requests only latch.
// - No request is offered while the return stack is full.
// - Any flag becoming set wakes the device.
`timescale 1ns/1ns
module mcu_irq_ctrl #(
  parameter int DEC_W = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire irq_pkg::periph_event_type PERIPH_EVT,
  input wire logic [irq_pkg::NUM_PINS-1:0] EXT_IRQ_PIN,
  input wire logic STACK_FULL,
  input wire logic SERVICE_ACK,
  output logic CORE_IRQ_REQ,
  output logic [irq_pkg::VEC_W-1:0] VECTOR_ID,
  output logic WAKE,
  output logic IRQ
);
  import irq_pkg::*;

  localparam int IDX_W = DEC_W - WORD_LSB;

  initial begin
    if (DEC_W < 6 || DEC_W > 31) begin
      $error("DEC_W must lie between 6 and 31");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bus_state_type state_q;
  bus_state_type state_d;
  logic [IDX_W-1:0] idx_q;
  logic mapped_q;
  logic [31:0] rdata_q;
  logic [NUM_PINS*EDGE_SEL_W-1:0] edge_sel_q;
  logic emi_q;
  pri_vec_type pri_flag_q;
  pri_vec_type pri_en_q;
  sub_vec_type sub_flag_q;
  sub_vec_type sub_en_q;
  logic [NUM_EVT-1:0] evt_st_q;
  logic [NUM_EVT-1:0] evt_mask_q;
  logic [VEC_W-1:0] vec_q;
  logic pend_q;
  logic wake_q;

  logic take;
  logic wr_go;
  logic [31:0] rd_word;
  logic [NUM_PINS-1:0] pin_hit;
  pri_vec_type pri_set;
  pri_vec_type pri_clr;
  pri_vec_type pri_wm;
  pri_vec_type pri_wf;
  pri_vec_type pri_we;
  pri_vec_type pri_flag_d;
  pri_vec_type elig;
  sub_vec_type sub_set;
  sub_vec_type sub_wm;
  sub_vec_type sub_wf;
  sub_vec_type sub_we;
  sub_vec_type sub_flag_d;
  logic [NUM_GRP-1:0] grp_hit;
  logic [NUM_EVT-1:0] evt_set;
  logic [VEC_W-1:0] vec_d;
  logic emi_wr;

  // ----------------------------------------------------------------
  // AHB-Lite slave: writes take no wait state, reads take one
  // ----------------------------------------------------------------
  assign take = HSEL & HTRANS[1] & HREADY;
  assign wr_go = (state_q == BUS_WR) & mapped_q;

  // Phase sequencing
  always_comb begin
    case (state_q)
      BUS_RD_WAIT: state_d = BUS_RD_DONE;
      BUS_IDLE, BUS_WR, BUS_RD_DONE: begin
        if (take) begin
          state_d = HWRITE ? BUS_WR : BUS_RD_WAIT;
        end else begin
          state_d = BUS_IDLE;
        end
      end
      default: state_d = BUS_IDLE;
    endcase
  end

  // Address phase capture; addresses beyond the map decode as unmapped
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= BUS_IDLE;
      idx_q <= '0;
      mapped_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        idx_q <= HADDR[DEC_W-1:WORD_LSB];
        mapped_q <= (HADDR[31:DEC_W] == '0) && (HADDR[DEC_W-1:WORD_LSB] < IDX_W'(REG_COUNT));
      end
    end
  end

  // Read data sampled in the wait state, so a write just before is seen
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= '0;
    end else if (state_q == BUS_RD_WAIT) begin
      rdata_q <= mapped_q ? rd_word : '0;
    end
  end

  assign HRDATA = rdata_q;
  assign HREADYOUT = (state_q != BUS_RD_WAIT);
  assign HRESP = 1'b0;

  // ----------------------------------------------------------------
  // Register read assembly from the field tables
  // ----------------------------------------------------------------
  // Bits not placed here stay zero
  always_comb begin
    rd_word = '0;
    case (idx_q)
      IDX_W'(REG_EDGE_SEL): rd_word[NUM_PINS*EDGE_SEL_W-1:0] = edge_sel_q;
      IDX_W'(REG_CTRL_A): rd_word[EMI_BIT] = emi_q;
      IDX_W'(REG_EVT_STATUS): rd_word[NUM_EVT-1:0] = evt_st_q;
      IDX_W'(REG_EVT_MASK): rd_word[NUM_EVT-1:0] = evt_mask_q;
      default: rd_word = '0;
    endcase
    for (int i = 0; i < NUM_PRI; i++) begin
      if (idx_q == IDX_W'(PRI_REG[i])) begin
        rd_word[PRI_FLAG_BIT[i]] = pri_flag_q[i];
        rd_word[PRI_EN_BIT[i]] = pri_en_q[i];
      end
    end
    for (int j = 0; j < NUM_SUB; j++) begin
      if (idx_q == IDX_W'(REG_GRP_A + SUB_GRP[j])) begin
        rd_word[SUB_FLAG_BIT[j]] = sub_flag_q[j];
        rd_word[SUB_EN_BIT[j]] = sub_en_q[j];
      end
    end
  end

  // Write decode into per-source masks and values
  always_comb begin
    pri_wm = '0;
    pri_wf = '0;
    pri_we = '0;
    sub_wm = '0;
    sub_wf = '0;
    sub_we = '0;
    for (int i = 0; i < NUM_PRI; i++) begin
      pri_wm[i] = wr_go && (idx_q == IDX_W'(PRI_REG[i]));
      pri_wf[i] = HWDATA[PRI_FLAG_BIT[i]];
      pri_we[i] = HWDATA[PRI_EN_BIT[i]];
    end
    for (int j = 0; j < NUM_SUB; j++) begin
      sub_wm[j] = wr_go && (idx_q == IDX_W'(REG_GRP_A + SUB_GRP[j]));
      sub_wf[j] = HWDATA[SUB_FLAG_BIT[j]];
      sub_we[j] = HWDATA[SUB_EN_BIT[j]];
    end
  end

  // ----------------------------------------------------------------
  // External pins
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    irq_pin_edge #(
      .SYNC_STAGES(2)
    ) u_edge (
      .clk(CLK),
      .arst_n(ARST_N),
      .pin(EXT_IRQ_PIN[g]),
      .edge_sel(edge_sel_q[g*EDGE_SEL_W +: EDGE_SEL_W]),
      .hit_q(pin_hit[g])
    );
  end

  // Edge select register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      edge_sel_q <= '0;
    end else if (wr_go && idx_q == IDX_W'(REG_EDGE_SEL)) begin
      edge_sel_q <= HWDATA[NUM_PINS*EDGE_SEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Request flags: a hardware set always beats a clear in the same cycle
  // ----------------------------------------------------------------
  // Group summaries only count sub-flags whose own enable is set
  always_comb begin
    grp_hit = '0;
    for (int j = 0; j < NUM_SUB; j++) begin
      if (sub_flag_q[j] && sub_en_q[j]) begin
        grp_hit[SUB_GRP[j]] = 1'b1;
      end
    end
  end

  // Source to flag mapping
  always_comb begin
    pri_set = '0;
    pri_set[P_PIN0] = pin_hit[0];
    pri_set[P_PIN1] = pin_hit[1];
    pri_set[P_CMP] = PERIPH_EVT.comparator;
    pri_set[P_ADC] = PERIPH_EVT.converter;
    pri_set[P_TB0] = PERIPH_EVT.timebase0;
    pri_set[P_TB1] = PERIPH_EVT.timebase1;
    pri_set[P_IIC] = PERIPH_EVT.two_wire;
    pri_set[P_UART] = PERIPH_EVT.async_serial;
    pri_set[P_MF0 +: NUM_GRP] = grp_hit;
    sub_set = '0;
    sub_set[S_T0P] = PERIPH_EVT.timer0_cmp_p;
    sub_set[S_T0A] = PERIPH_EVT.timer0_cmp_a;
    sub_set[S_T1P] = PERIPH_EVT.timer1_cmp_p;
    sub_set[S_T1A] = PERIPH_EVT.timer1_cmp_a;
    sub_set[S_T2P] = PERIPH_EVT.timer2_cmp_p;
    sub_set[S_T2A] = PERIPH_EVT.timer2_cmp_a;
    sub_set[S_LVD] = PERIPH_EVT.voltage_detect;
    sub_set[S_EEP] = PERIPH_EVT.eeprom;
  end

  // Service entry clears only the flag the core was shown
  assign pri_clr = SERVICE_ACK ? (pri_vec_type'(1) << vec_q) : '0;
  assign pri_flag_d = pri_set | (pri_wm & pri_wf) | (~pri_wm & pri_flag_q & ~pri_clr);
  assign sub_flag_d = sub_set | (sub_wm & sub_wf) | (~sub_wm & sub_flag_q);

  // Flags and enables
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pri_flag_q <= '0;
      pri_en_q <= '0;
      sub_flag_q <= '0;
      sub_en_q <= '0;
    end else begin
      pri_flag_q <= pri_flag_d;
      pri_en_q <= (pri_wm & pri_we) | (~pri_wm & pri_en_q);
      sub_flag_q <= sub_flag_d;
      sub_en_q <= (sub_wm & sub_we) | (~sub_wm & sub_en_q);
    end
  end

  // Global enable; the acknowledge wins over a software set in the same cycle
  assign emi_wr = wr_go && (idx_q == IDX_W'(REG_CTRL_A));
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      emi_q <= 1'b0;
    end else if (SERVICE_ACK) begin
      emi_q <= 1'b0;
    end else if (emi_wr) begin
      emi_q <= HWDATA[EMI_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Vectoring toward the core
  // ----------------------------------------------------------------
  // Lowest index wins among the enabled pending flags
  always_comb begin
    elig = pri_flag_q & pri_en_q;
    vec_d = '0;
    for (int i = NUM_PRI - 1; i >= 0; i--) begin
      if (elig[i]) begin
        vec_d = VEC_W'(i);
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vec_q <= '0;
      pend_q <= 1'b0;
    end else begin
      vec_q <= vec_d;
      pend_q <= |elig;
    end
  end

  // Combinational so that a full stack drops it in the same cycle
  assign CORE_IRQ_REQ = emi_q & pend_q & ~STACK_FULL;
  assign VECTOR_ID = vec_q;

  // Wake pulse in the same cycle that any flag goes from clear to set
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= |(pri_flag_d & ~pri_flag_q) | |(sub_flag_d & ~sub_flag_q);
    end
  end
  assign WAKE = wake_q;

  // ----------------------------------------------------------------
  // Block event status, mask and interrupt line
  // ----------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[E_SERVICE] = SERVICE_ACK;
    evt_set[E_WAKE] = wake_q;
    evt_set[E_STACK_BLOCK] = emi_q & pend_q & STACK_FULL;
  end

  // Write one to clear; a new event in the same cycle survives
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_st_q <= '0;
      evt_mask_q <= '0;
    end else begin
      if (wr_go && idx_q == IDX_W'(REG_EVT_STATUS)) begin
        evt_st_q <= evt_set | (evt_st_q & ~HWDATA[NUM_EVT-1:0]);
      end else begin
        evt_st_q <= evt_set | evt_st_q;
      end
      if (wr_go && idx_q == IDX_W'(REG_EVT_MASK)) begin
        evt_mask_q <= HWDATA[NUM_EVT-1:0];
      end
    end
  end
  assign IRQ = |(evt_st_q & evt_mask_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_global_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
    (SERVICE_ACK ##1 !emi_wr) |=> !CORE_IRQ_REQ)
    else $error("request offered with global enable clear");
  a_ack_clears_emi: assert property (@(posedge CLK) disable iff (!ARST_N)
    SERVICE_ACK |=> !emi_q)
    else $error("global enable survived service entry");
  a_req_needs_en: assert property (@(posedge CLK) disable iff (!ARST_N)
    CORE_IRQ_REQ |-> (($past(pri_flag_q & pri_en_q) & (pri_vec_type'(1) << vec_q)) != '0))
    else $error("request without an enabled flag");
  a_stack_full: assert property (@(posedge CLK) disable iff (!ARST_N)
    (STACK_FULL && emi_q && pend_q) |-> !CORE_IRQ_REQ ##1 evt_st_q[E_STACK_BLOCK])
    else $error("request offered while stack full");
  a_pin0_flag: assert property (@(posedge CLK) disable iff (!ARST_N)
    pin_hit[0] |=> pri_flag_q[P_PIN0])
    else $error("pin 0 edge did not set its flag");
  a_event_flag: assert property (@(posedge CLK) disable iff (!ARST_N)
    (PERIPH_EVT.converter ##1 (!pri_wm[P_ADC] && !SERVICE_ACK)) |-> ##1 pri_flag_q[P_ADC])
    else $error("converter flag lost");
  a_summary_set: assert property (@(posedge CLK) disable iff (!ARST_N)
    (sub_flag_q[S_LVD] && sub_en_q[S_LVD]) |=> pri_flag_q[P_MF0 + SUB_GRP[S_LVD]])
    else $error("group summary not set");
  a_wake_pulse: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(pri_flag_q[P_TB1]) |-> WAKE)
    else $error("flag set without wake");
  a_reserved_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
    (state_q == BUS_RD_WAIT && idx_q == IDX_W'(REG_EDGE_SEL)) |=> HRDATA[31:NUM_PINS*EDGE_SEL_W] == '0)
    else $error("reserved bits read nonzero");
  a_read_wait: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");

endmodule

// ===== irq_core_model.sv
// Behavioural model of the processor core that takes vectored requests
`timescale 1ns/1ns
module irq_core_model (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic REQ,
  input wire logic [irq_pkg::VEC_W-1:0] VECTOR,
  input wire logic [3:0] DELAY,
  output logic ACK,
  output logic [irq_pkg::VEC_W-1:0] TAKEN_VEC,
  output logic [7:0] ACK_COUNT
);
  import irq_pkg::*;
  logic [3:0] wait_q;
  // ----------------------------------------------------------------
  // Service entry
  // ----------------------------------------------------------------
  // Ack only while the request stands; a slow core waits DELAY cycles
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ACK <= 1'b0;
      TAKEN_VEC <= '0;
      ACK_COUNT <= 8'h00;
      wait_q <= 4'h0;
    end else begin
      ACK <= REQ && !ACK && (wait_q == DELAY);
      if (REQ && !ACK) begin
        if (wait_q == DELAY) begin
          TAKEN_VEC <= VECTOR;
          ACK_COUNT <= ACK_COUNT + 8'h01;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule

// ===== tb_top.sv
// Self-checking testbench of the interrupt request controller
`timescale 1ns/1ns
module tb_top;
  import irq_pkg::*;
  logic clk, arst_n, hsel, hwrite, hreadyout, hresp, stack, ack, req, wake, irq, wake_seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, pin;
  logic [3:0] vec, tvec, dly;
  logic [7:0] acks;
  periph_event_type evt;
  int fail_count, n_tests, cyc;
  mcu_irq_ctrl dut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .PERIPH_EVT(evt), .EXT_IRQ_PIN(pin), .STACK_FULL(stack), .SERVICE_ACK(ack), .CORE_IRQ_REQ(req),
    .VECTOR_ID(vec), .WAKE(wake), .IRQ(irq));
  irq_core_model core (.CLK(clk), .ARST_N(arst_n), .REQ(req), .VECTOR(vec), .DELAY(dly), .ACK(ack),
    .TAKEN_VEC(tvec), .ACK_COUNT(acks));
  // ----------------------------------------------------------------
  // Clock, timeout and wake monitor
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // A hang in a bus wait ends here rather than running forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) wake_seen <= 1'b1;
    if (cyc == 8000) begin
      fail_count++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is looked at mid-cycle, where it is settled, then taken at the next edge
  task automatic bus(input logic w, input int idx, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(idx * 4);
    hwrite <= w;
    do @(negedge clk); while (hreadyout !== 1'b1);
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    chk({31'h0, hresp}, 32'h0);
    @(posedge clk);
  endtask
  task automatic wr(input int idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rdc(input int idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    chk(x, exp);
  endtask
  task automatic pulse(input periph_event_type e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask
  task automatic wait_ack(input logic [7:0] base);
    for (int k = 0; k < 60 && acks === base; k++) @(negedge clk);
    chk({24'h0, acks}, {24'h0, base + 8'h01});
  endtask
  task automatic pin_step(input int p, input logic v, input logic exp);
    @(posedge clk);
    pin[p] <= v;
    repeat (8) @(negedge clk);
    bus(1'b0, p ? REG_CTRL_C : REG_CTRL_A, 32'h0, rd);
    chk({31'h0, rd[p ? 5 : 4]}, {31'h0, exp});
    wr(p ? REG_CTRL_C : REG_CTRL_A, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, read-back masks, stack-full blocking, unmapped read
  task automatic t_regs;
    logic [7:0] msk [7];
    msk = '{8'h0f, 8'h7f, 8'hff, 8'hff, 8'h33, 8'hff, 8'h33};
    stack <= 1'b1;
    for (int i = 0; i < 7; i++) rdc(i, 32'h0);
    for (int i = 0; i < 7; i++) wr(i, 32'hff);
    for (int i = 0; i < 7; i++) rdc(i, {24'h0, msk[i]});
    @(negedge clk);
    chk({31'h0, req}, 32'h0);
    bus(1'b0, REG_EVT_STATUS, 32'h0, rd);
    chk(rd & 32'h4, 32'h4);
    rdc(REG_COUNT, 32'h0);
    for (int i = 6; i >= 0; i--) wr(i, 32'h0);
    wr(REG_EVT_STATUS, 32'h7);
    stack <= 1'b0;
  endtask
  // Comparator serviced by a prompt or a slow core
  task automatic t_service(input logic [3:0] d);
    periph_event_type e;
    logic [7:0] base;
    e = '0;
    e.comparator = 1'b1;
    dly <= d;
    wake_seen = 1'b0;
    base = acks;
    wr(REG_EVT_MASK, 32'h1);
    wr(REG_CTRL_A, 32'h5);
    pulse(e);
    wait_ack(base);
    chk({28'h0, tvec}, P_CMP);
    // A second request after entry must only latch, since the global enable is gone
    pulse(e);
    @(negedge clk);
    @(negedge clk);
    chk({31'h0, req}, 32'h0);
    rdc(REG_CTRL_A, 32'h24);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, wake_seen}, 32'h1);
    wr(REG_EVT_STATUS, 32'h7);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(REG_CTRL_A, 32'h0);
  endtask
  // Individual enable and global enable both gate the request
  task automatic t_gate;
    periph_event_type e;
    logic [7:0] base;
    e = '0;
    e.converter = 1'b1;
    wr(REG_CTRL_A, 32'h1);
    pulse(e);
    repeat (6) @(negedge clk);
    chk({31'h0, req}, 32'h0);
    rdc(REG_CTRL_B, 32'h40);
    wr(REG_CTRL_A, 32'h0);
    wr(REG_CTRL_B, 32'h44);
    repeat (6) @(negedge clk);
    chk({31'h0, req}, 32'h0);
    base = acks;
    wr(REG_CTRL_A, 32'h1);
    wait_ack(base);
    chk({28'h0, tvec}, P_ADC);
    wr(REG_CTRL_B, 32'h0);
  endtask
  // Enabled sub-flag raises its group summary
  task automatic t_group;
    periph_event_type e;
    e = '0;
    e.timer1_cmp_a = 1'b1;
    wr(REG_GRP_B, 32'h2);
    pulse(e);
    repeat (4) @(negedge clk);
    rdc(REG_CTRL_B, 32'h10);
    rdc(REG_GRP_B, 32'h22);
    wr(REG_GRP_B, 32'h0);
    wr(REG_CTRL_B, 32'h0);
  endtask
  // Every edge mode on both pins, rising then falling
  task automatic t_pins;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr(REG_EDGE_SEL, 32'(m << (2 * p)));
        pin_step(p, 1'b1, m[0]);
        pin_step(p, 1'b0, m[1]);
      end
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, hsel, hwrite, stack, wake_seen} = '0;
    {haddr, hwdata, htrans, pin, dly} = '0;
    evt = '0;
    {fail_count, n_tests, cyc} = '0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_service(4'h0);
    t_service(4'h5);
    t_gate();
    t_group();
    t_pins();
    conclude();
  end
endmodule
